// ### shared/bsp_params.svh
// Constants for the boot select and code protect block
// Assumes inclusion by bare name from any design file
`ifndef BSP_PARAMS_SVH
`define BSP_PARAMS_SVH
`define BSP_OPT_ERASED      8'hFF
`define BSP_OPT_LOCK        0
`define BSP_OPT_TBL_INHIBIT 1
`define BSP_OPT_STRAP_AB    4
`define BSP_OPT_STRAP_C     5
`define BSP_OPT_FAST_CLK    7
`define BSP_CPC_ENTER_LDR   8'h03
`define BSP_CPC_UPDATE_ONLY 8'h01
`define BSP_CPC_RESTART     7
`define BSP_CPC_RESET       8'h00
`define BSP_RST_PULSE_CYC   4
`endif

// ### shared/bsp_pkg.sv
// Types for the boot select and code protect block
// Assumes no other package
package bsp_pkg;
  typedef enum logic { BSP_MAIN_FLASH, BSP_LOADER_FLASH } bsp_boot_t;
endpackage : bsp_pkg

// ### hdl/bsp_option_store.sv
// Non-volatile option byte model: program clears bits, erase-all sets them
// Assumes writer-mode strobes are single-cycle and synchronous to clock
// Assumes an erase-all before first use; content is unknown until then
`timescale 1ns/1ns
`include "bsp_params.svh"
module bsp_option_store #(
  parameter int W = 8
) (
  input  wire logic         clock,
  input  wire logic         arst_n,
  input  wire logic         prog_wr,
  input  wire logic [W-1:0] prog_data,
  input  wire logic         erase_all,
  output logic      [W-1:0] opt_bits
);
  // Content survives external reset; only erase-all sets bits again
  logic [W-1:0] opt_r;
  always_ff @(posedge clock) begin
    if (erase_all) begin
      opt_r <= W'(`BSP_OPT_ERASED);
    end else if (prog_wr) begin
      opt_r <= opt_r & prog_data;
    end
  end
  assign opt_bits = opt_r;
endmodule : bsp_option_store

// ### hdl/bsp_boot_select.sv
// Boot-source selection, in-system programming handover and code protection
// Assumes strap pins and writer strobes synchronous to clock; cpu_idle from the core
`timescale 1ns/1ns
`include "bsp_params.svh"
// How it works
// - Reset boots main flash by default
// - Bit4 low, straps A,B low: loader boot
// - Bit5 low, strap C low: loader boot
// - Control 03h then idle: loader, reset pulse
// - Bank select picks main bank to update
// - Restart bit: back to main, restart CPU
// - Control 01h then idle: update, stay main
// - Option register only in writer mode
// - Programmed bits return only by erase-all
// - Erased option bits read as one
// - Lock bit zero blocks external reads and programs
// - Restricted: external fetch reads external only
// - Internal fetch may read everything
// - Restriction bit one: no table restriction
module bsp_boot_select #(
  parameter int RST_CYC = `BSP_RST_PULSE_CYC
) (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       boot_strap_pin_a,
  input  wire logic       boot_strap_pin_b,
  input  wire logic       boot_strap_pin_c,
  input  wire logic       cpu_idle,
  input  wire logic       cpc_wr,
  input  wire logic [7:0] cpc_wdata,
  input  wire logic       bank_wr,
  input  wire logic       bank_wdata,
  input  wire logic       writer_mode,
  input  wire logic       opt_prog_wr,
  input  wire logic [7:0] opt_prog_data,
  input  wire logic       opt_erase_all,
  input  wire logic       opt_rd,
  input  wire logic       flash_rd,
  input  wire logic [7:0] flash_rdata,
  input  wire logic       tbl_rd,
  input  wire logic       tbl_from_ext,
  input  wire logic       tbl_target_int,
  output logic            boot_loader,
  output logic            cpu_reset,
  output logic      [7:0] chip_program_control,
  output logic            flash_bank_select,
  output logic            update_active,
  output logic      [7:0] writer_rdata,
  output logic            writer_refused,
  output logic            tbl_int_allowed,
  output logic            fast_clock_range
);
  // ****************************************
  // Option store
  // ****************************************
  logic [7:0] opt_bits;
  logic       locked;
  logic       prog_ok;
  assign locked  = ~opt_bits[`BSP_OPT_LOCK];
  assign prog_ok = writer_mode & ~locked;
  bsp_option_store #(.W(8)) u_opt (
    .clock     (clock),
    .arst_n    (arst_n),
    .prog_wr   (opt_prog_wr & prog_ok),
    .prog_data (opt_prog_data),
    .erase_all (opt_erase_all & writer_mode),
    .opt_bits  (opt_bits)
  );

  // ****************************************
  // Strap sampling
  // ****************************************
  logic strap_loader;
  logic in_reset_r;
  assign strap_loader =
    (~opt_bits[`BSP_OPT_STRAP_AB] & ~boot_strap_pin_a & ~boot_strap_pin_b)
    | (~opt_bits[`BSP_OPT_STRAP_C] & ~boot_strap_pin_c);

  // Marks the first edge after release, where straps are caught
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      in_reset_r <= 1'b1;
    end else begin
      in_reset_r <= 1'b0;
    end
  end

  // ****************************************
  // Boot source and handover
  // ****************************************
  bsp_pkg::bsp_boot_t boot_r;
  logic               enter_ldr;
  logic               sw_restart;
  assign enter_ldr  = cpu_idle & (chip_program_control == `BSP_CPC_ENTER_LDR);
  assign sw_restart = cpc_wr & cpc_wdata[`BSP_CPC_RESTART];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      boot_r <= bsp_pkg::BSP_MAIN_FLASH;
    end else if (in_reset_r) begin
      boot_r <= strap_loader ? bsp_pkg::BSP_LOADER_FLASH
                             : bsp_pkg::BSP_MAIN_FLASH;
    end else if (sw_restart) begin
      boot_r <= bsp_pkg::BSP_MAIN_FLASH;
    end else if (enter_ldr) begin
      boot_r <= bsp_pkg::BSP_LOADER_FLASH;
    end
  end
  assign boot_loader = (boot_r == bsp_pkg::BSP_LOADER_FLASH);

  // Control register; restart bit self-clears, restart and handover clear it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      chip_program_control <= `BSP_CPC_RESET;
    end else if (sw_restart || enter_ldr) begin
      chip_program_control <= `BSP_CPC_RESET;
    end else if (cpc_wr) begin
      chip_program_control <= cpc_wdata;
    end
  end

  // Update-in-place mode: idle with 01h, main flash kept
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      update_active <= 1'b0;
    end else if (cpu_idle && chip_program_control == `BSP_CPC_UPDATE_ONLY) begin
      update_active <= 1'b1;
    end else if (!cpu_idle) begin
      update_active <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flash_bank_select <= 1'b0;
    end else if (bank_wr) begin
      flash_bank_select <= bank_wdata;
    end
  end

  // CPU restart pulse of RST_CYC cycles
  logic [7:0] rst_cnt_r;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_cnt_r <= 8'h00;
    end else if (sw_restart || enter_ldr) begin
      rst_cnt_r <= 8'(RST_CYC);
    end else if (rst_cnt_r != 8'h00) begin
      rst_cnt_r <= rst_cnt_r - 8'h01;
    end
  end
  assign cpu_reset = (rst_cnt_r != 8'h00);

  // ****************************************
  // Writer access and protection
  // ****************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      writer_rdata   <= 8'h00;
      writer_refused <= 1'b0;
    end else begin
      writer_refused <= (opt_rd | flash_rd | opt_prog_wr) & ~prog_ok;
      if (opt_rd && prog_ok) begin
        writer_rdata <= opt_bits;
      end else if (flash_rd && prog_ok) begin
        writer_rdata <= flash_rdata;
      end else if (opt_rd || flash_rd) begin
        writer_rdata <= 8'h00;
      end
    end
  end

  // Table read gate: only external fetch under restriction is barred
  assign tbl_int_allowed = tbl_rd & tbl_target_int &
    (~tbl_from_ext | opt_bits[`BSP_OPT_TBL_INHIBIT]);

  assign fast_clock_range = opt_bits[`BSP_OPT_FAST_CLK];
endmodule : bsp_boot_select

// ### verif/bsp_strap_model.sv
// Board strap model: pull-ups, jumpers pull pins low
// Assumes jumper inputs are active low
`timescale 1ns/1ns
module bsp_strap_model (
  input  wire logic jump_ab_n,
  input  wire logic jump_c_n,
  output logic      pin_a,
  output logic      pin_b,
  output logic      pin_c
);
  assign pin_a = jump_ab_n;
  assign pin_b = jump_ab_n;
  assign pin_c = jump_c_n;
endmodule : bsp_strap_model

// ### verif/bsp_boot_chk.sv
// Port checker for bsp_boot_select
// Assumes bind into bsp_boot_select
`timescale 1ns/1ns
module bsp_boot_chk #(
  parameter int RST_CYC = 4
) (
  input wire logic       clock,
  input wire logic       arst_n,
  input wire logic       cpu_idle,
  input wire logic       cpc_wr,
  input wire logic [7:0] cpc_wdata,
  input wire logic       writer_mode,
  input wire logic       opt_rd,
  input wire logic       tbl_rd,
  input wire logic       tbl_from_ext,
  input wire logic       tbl_target_int,
  input wire logic       boot_loader,
  input wire logic       cpu_reset,
  input wire logic [7:0] chip_program_control,
  input wire logic       update_active,
  input wire logic [7:0] writer_rdata,
  input wire logic       writer_refused,
  input wire logic       tbl_int_allowed
);
  int n_r;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Length of restart pulse
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      n_r <= 0;
    else
      n_r <= cpu_reset ? n_r + 1 : 0;
  end
  a_pulse_len: assert property ($fell(cpu_reset) |-> n_r == RST_CYC)
    else $error("restart pulse length");
  a_refuse_mode: assert property (opt_rd && !writer_mode |=>
    writer_refused && writer_rdata == 8'h00) else $error("read outside writer mode");
  a_tbl_block: assert property (!tbl_rd || !tbl_target_int |-> !tbl_int_allowed)
    else $error("table read grant");
  a_tbl_internal: assert property (tbl_rd && tbl_target_int && !tbl_from_ext |->
    tbl_int_allowed) else $error("internal table read");
  a_enter_ldr: assert property (chip_program_control == 8'h03 && cpu_idle |->
    ##[1:2] (boot_loader && cpu_reset)) else $error("loader handover");
  a_restart_main: assert property (cpc_wr && cpc_wdata[7] |->
    ##[1:3] (!boot_loader && cpu_reset)) else $error("restart");
  a_update_on: assert property (chip_program_control == 8'h01 && cpu_idle |->
    ##[1:2] update_active) else $error("update mode");
  a_stay_main: assert property (chip_program_control == 8'h01 && cpu_idle &&
    !boot_loader |=> !boot_loader[*2]) else $error("update left main");
endmodule : bsp_boot_chk
bind bsp_boot_select bsp_boot_chk #(.RST_CYC(RST_CYC)) u_chk (.*);

// ### verif/tb_top.sv
// Self-checking bench for bsp_boot_select
// Assumes strap model and checker compiled first
`timescale 1ns/1ns
`include "bsp_params.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
  logic clock = '0, arst_n = '0, cpu_idle = '0, cpc_wr = '0, bank_wr = '0, bank_wdata = '0;
  logic writer_mode = '1, opt_prog_wr = '0, opt_erase_all = '0, opt_rd = '0, flash_rd = '0;
  logic tbl_rd = '0, tbl_from_ext = '0, tbl_target_int = '0, jump_ab_n = '0, jump_c_n = '0;
  logic [7:0] cpc_wdata = '0, opt_prog_data = '0, flash_rdata = '0, chip_program_control;
  logic [7:0] writer_rdata;
  logic boot_strap_pin_a, boot_strap_pin_b, boot_strap_pin_c, boot_loader, cpu_reset;
  logic flash_bank_select, update_active, writer_refused, tbl_int_allowed, fast_clock_range;
  int errors = 0, comparisons = 0, ticks = 0, n;
  bsp_strap_model u_straps (.jump_ab_n(jump_ab_n), .jump_c_n(jump_c_n),
    .pin_a(boot_strap_pin_a), .pin_b(boot_strap_pin_b), .pin_c(boot_strap_pin_c));
  bsp_boot_select u_dut (.*);
  always #25 clock = ~clock;
  always @(posedge clock) begin
    ticks++;
    if (ticks == 3000) begin
      errors++;
      wrap_up();
    end
  end
  // One strobe: 0 read, 1 program, 2 erase, 3 control, 4 bank
  task automatic op(int k, logic [7:0] d);
    @(posedge clock);
    {opt_prog_data, cpc_wdata, bank_wdata} <= {d, d, d[0]};
    case (k)
      0: opt_rd <= '1;
      1: opt_prog_wr <= '1;
      2: opt_erase_all <= '1;
      3: cpc_wr <= '1;
      default: bank_wr <= '1;
    endcase
    @(posedge clock);
    {opt_rd, opt_prog_wr, opt_erase_all, cpc_wr, bank_wr} <= '0;
    #1;
  endtask : op
  task automatic t_reset;
    `CHK("boot", 1'h0, boot_loader)
    `CHK("fast", 1'h1, fast_clock_range)
    {jump_ab_n, jump_c_n, tbl_rd, tbl_from_ext, tbl_target_int} <= '1;
    op(0, 8'h00);
    `CHK("opt", 8'hff, writer_rdata)
    `CHK("tbl", 1'h1, tbl_int_allowed)
  endtask : t_reset
  task automatic t_prog;
    op(1, 8'h7d);
    op(1, 8'hff);
    op(0, 8'h00);
    `CHK("opt", 8'h7d, writer_rdata)
    `CHK("fast", 1'h0, fast_clock_range)
    `CHK("tbl", 1'h0, tbl_int_allowed)
    @(posedge clock);
    tbl_from_ext <= '0;
    #1;
    `CHK("tbl", 1'h1, tbl_int_allowed)
  endtask : t_prog
  task automatic t_lock;
    op(1, 8'hfe);
    op(0, 8'h00);
    `CHK("refused", 1'h1, writer_refused)
    op(2, 8'h00);
    op(0, 8'h00);
    `CHK("opt", 8'hff, writer_rdata)
    @(posedge clock);
    writer_mode <= '0;
    op(1, 8'h00);
    op(0, 8'h00);
    `CHK("refused", 1'h1, writer_refused)
    `CHK("opt", 8'h00, writer_rdata)
    @(posedge clock);
    writer_mode <= '1;
    op(0, 8'h00);
    `CHK("opt", 8'hff, writer_rdata)
  endtask : t_lock
  task automatic t_isp;
    op(3, `BSP_CPC_ENTER_LDR);
    @(posedge clock);
    cpu_idle <= '1;
    @(posedge clock);
    cpu_idle <= '0;
    n = 0;
    #1;
    repeat (10) begin
      n += int'(cpu_reset);
      @(posedge clock);
      #1;
    end
    `CHK("loader", 1'h1, boot_loader)
    `CHK("pulse", `BSP_RST_PULSE_CYC, n)
    op(4, 8'h01);
    `CHK("bank", 1'h1, flash_bank_select)
    op(3, 8'h80);
    repeat (6) @(posedge clock);
    `CHK("loader", 1'h0, boot_loader)
    op(3, `BSP_CPC_UPDATE_ONLY);
    @(posedge clock);
    cpu_idle <= '1;
    repeat (2) @(posedge clock);
    `CHK("update", 1'h1, update_active)
    `CHK("loader", 1'h0, boot_loader)
    cpu_idle <= '0;
  endtask : t_isp
  task automatic rst_pulse;
    @(posedge clock);
    arst_n <= '0;
    repeat (3) @(posedge clock);
    arst_n <= '1;
    repeat (2) @(posedge clock);
    #1;
  endtask : rst_pulse
  task automatic t_strap;
    op(1, 8'hef);
    {jump_ab_n, jump_c_n} <= 2'b01;
    rst_pulse();
    `CHK("strap_ab", 1'h1, boot_loader)
    jump_ab_n <= '1;
    rst_pulse();
    `CHK("strap_ab", 1'h0, boot_loader)
    op(2, 8'h00);
    op(1, 8'hdf);
    {jump_ab_n, jump_c_n} <= 2'b10;
    rst_pulse();
    `CHK("strap_c", 1'h1, boot_loader)
    op(2, 8'h00);
    rst_pulse();
    `CHK("strap_c", 1'h0, boot_loader)
  endtask : t_strap
  task automatic wrap_up;
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (4) @(posedge clock);
    op(2, 8'h00);
    repeat (4) @(posedge clock);
    arst_n <= '1;
    repeat (2) @(posedge clock);
    t_reset();
    t_prog();
    t_lock();
    t_isp();
    t_strap();
    wrap_up();
  end
endmodule : tb_top
